// >>> core/hts_sensor_slave.sv
/*
 Two-wire target front end and mode control of a humidity/temperature
 sensor: pointer register, result/config/id registers, measurement
 sequencing, supply-low flag and heater gating.
 Assumes open-drain SDA resolved outside (o_sda_oe pulls low), SCL is
 only ever an input, and analog results are steady at i_*_result.
*/
// What this block does
// - only a target, never drives SCL
// - answers fixed address 1000000 only
// - first write byte loads the pointer
// - reads return register at stored pointer
// - pointer-only write is valid transfer
// - MSB first, high byte then low
// - data written to read-only registers nacked
// - unknown pointer byte is nacked
// - foreign address byte is nacked
// - ready for measurements within 15 ms
// - during start-up only ids readable
// - sleep, measure on trigger, back sleep
// - commands accepted while sleeping
// - supply-low flag bit 11, refreshed
// - heater enable is config bit 13
// - heater on while measuring, one clock late
// - humidity 8/11/14, temperature 11/14 bits
// - pointer resets to 0x00
// - pointer 0x00 write triggers, both sequence
// - stale result read is nacked
// - result write aborts, read does not
`timescale 1ns/1ps
`include "hts_params.svh"
`default_nettype none
module hts_sensor_slave #(
    parameter int P_STARTUP_CYC = `HTS_CYC(`HTS_STARTUP_NS),
    parameter int P_T11_CYC = `HTS_CYC(`HTS_T11_NS),
    parameter int P_T14_CYC = `HTS_CYC(`HTS_T14_NS),
    parameter int P_H8_CYC = `HTS_CYC(`HTS_H8_NS),
    parameter int P_H11_CYC = `HTS_CYC(`HTS_H11_NS),
    parameter int P_H14_CYC = `HTS_CYC(`HTS_H14_NS),
    // identity values below are arbitrary
    parameter logic [47:0] P_SERIAL_ID = 48'h0123_4567_8900,
    parameter logic [15:0] P_MFR_ID = 16'h0A5A,
    parameter logic [15:0] P_DEV_ID = 16'h0B6B
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_supply_low,
    input wire logic [13:0] i_temp_result,
    input wire logic [13:0] i_hum_result,
    output logic o_heater_on,
    output logic o_measuring,
    output logic o_ready,
    output hts_pkg::hts_meas_state_type o_meas_state
);
    import hts_pkg::*;

    if (P_STARTUP_CYC < 1 || P_T11_CYC < 1 || P_T14_CYC < 1 ||
        P_H8_CYC < 1 || P_H11_CYC < 1 || P_H14_CYC < 1 ||
        P_STARTUP_CYC > 24'hFFFFFF || P_H14_CYC > 24'hFFFFFF ||
        P_T14_CYC > 24'hFFFFFF)
    begin : g_bad_counts
        $error("hts_sensor_slave: cycle counts must fit 1..2^24-1");
    end

    // pins: three stages, level accepted once stages two and three agree
    logic [2:0] pin_in;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] filt;
    logic [2:0] filt_d;
    assign pin_in = {i_supply_low, i_sda, i_scl};

    // reset levels match the idle pins, so no false edge follows reset
    localparam logic [2:0] SYNC_INIT = `HTS_SYNC_INIT;

    genvar g;
    for (g = 0; g < 3; g++)
    begin : g_sync
        always_ff @(posedge i_clock)
        begin
            if (!i_rst_n)
            begin
                sy1[g] <= SYNC_INIT[g];
                sy2[g] <= SYNC_INIT[g];
                sy3[g] <= SYNC_INIT[g];
                filt[g] <= SYNC_INIT[g];
                filt_d[g] <= SYNC_INIT[g];
            end
            else
            begin
                sy1[g] <= pin_in[g];
                sy2[g] <= sy1[g];
                sy3[g] <= sy2[g];
                if (sy2[g] == sy3[g])
                    filt[g] <= sy3[g];
                filt_d[g] <= filt[g];
            end
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = filt[0] & ~filt_d[0];
    assign scl_fall = ~filt[0] & filt_d[0];
    assign bus_start = filt[0] & filt_d[0] & filt_d[1] & ~filt[1];
    assign bus_stop = filt[0] & filt_d[0] & ~filt_d[1] & filt[1];

    // start-up interval
    logic [23:0] boot_cnt;
    logic ready;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            boot_cnt <= 24'h000000;
            ready <= 1'b0;
        end
        else if (!ready)
        begin
            boot_cnt <= boot_cnt + 24'h000001;
            if (boot_cnt == 24'(P_STARTUP_CYC - 1))
                ready <= 1'b1;
        end
    end

    hts_bus_state_type bstate;
    hts_meas_state_type mstate;
    logic [15:0] cfg;
    logic [15:0] temp_reg;
    logic [15:0] hum_reg;
    logic temp_valid;
    logic hum_valid;
    logic [7:0] ptr;
    logic [7:0] tx_ptr;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic lo_next;
    logic wr_ok;
    logic mack;
    logic pend_trig;
    logic [7:0] cfg_hi;
    logic trig;
    logic abort_req;
    logic cfg_we;
    logic [15:0] cfg_wdata;

    function automatic logic ptr_ok(input logic [7:0] p);
        logic known;
        known = (p <= `HTS_PTR_CFG) || (p >= `HTS_PTR_SER0);
        return known && (ready || p >= `HTS_PTR_SER0);
    endfunction

    function automatic logic read_ok(input logic [7:0] p);
        logic stale;
        stale = (p == `HTS_PTR_TEMP && !temp_valid) ||
                (p == `HTS_PTR_HUM && !hum_valid);
        return ptr_ok(p) && !stale;
    endfunction

    function automatic logic [15:0] word_of(input logic [7:0] p);
        unique case (p)
            `HTS_PTR_TEMP: return temp_reg;
            `HTS_PTR_HUM: return hum_reg;
            `HTS_PTR_CFG: return cfg;
            `HTS_PTR_SER0: return P_SERIAL_ID[47:32];
            `HTS_PTR_SER1: return P_SERIAL_ID[31:16];
            `HTS_PTR_SER2: return P_SERIAL_ID[15:0];
            `HTS_PTR_MFR: return P_MFR_ID;
            `HTS_PTR_DEV: return P_DEV_ID;
            default: return 16'h0000;
        endcase
    endfunction

    // next byte to send after the master acknowledges; whole words are
    // fetched first since a select on a function result is not portable
    logic [7:0] next_tx_ptr;
    logic [7:0] next_tx_byte;
    logic [15:0] tx_word;
    logic [15:0] next_word;
    logic [15:0] ptr_word;
    always_comb
    begin
        next_tx_ptr = tx_ptr;
        tx_word = word_of(tx_ptr);
        ptr_word = word_of(ptr);
        if (!lo_next && tx_ptr == `HTS_PTR_TEMP && cfg[`HTS_BIT_MODE])
            next_tx_ptr = `HTS_PTR_HUM;
        next_word = word_of(next_tx_ptr);
        if (lo_next)
            next_tx_byte = tx_word[7:0];
        else
            next_tx_byte = next_word[15:8];
    end

    logic addr_match;
    assign addr_match = shreg[7:1] == `HTS_DEV_ADDR;

    // two-wire target engine; SDA is only ever pulled low
    always_ff @(posedge i_clock)
    begin
        trig <= 1'b0;
        abort_req <= 1'b0;
        cfg_we <= 1'b0;
        if (!i_rst_n)
        begin
            bstate <= ST_IDLE;
            ptr <= `HTS_PTR_TEMP;
            tx_ptr <= `HTS_PTR_TEMP;
            shreg <= 8'h00;
            cnt <= 4'h0;
            rw <= 1'b0;
            first <= 1'b0;
            lo_next <= 1'b0;
            wr_ok <= 1'b0;
            mack <= 1'b0;
            pend_trig <= 1'b0;
            cfg_hi <= 8'h00;
            cfg_wdata <= 16'h0000;
            o_sda_oe <= 1'b0;
        end
        else if (bus_start || bus_stop)
        begin
            // a pointer-only write ends here and fires the conversion
            trig <= pend_trig;
            pend_trig <= 1'b0;
            bstate <= bus_start ? ST_ADDR : ST_IDLE;
            cnt <= 4'h0;
            o_sda_oe <= 1'b0;
        end
        else
        begin
            unique case (bstate)
                ST_IDLE:
                    o_sda_oe <= 1'b0;
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg <= {shreg[6:0], filt[1]};
                        cnt <= cnt + 4'h1;
                    end
                    else if (scl_fall && cnt == 4'h8)
                    begin
                        cnt <= 4'h0;
                        if (bstate == ST_ADDR)
                        begin
                            rw <= shreg[0];
                            if (addr_match && (!shreg[0] || read_ok(ptr)))
                            begin
                                o_sda_oe <= 1'b1;
                                bstate <= ST_ADDR_ACK;
                            end
                            else
                                bstate <= ST_IDLE;
                        end
                        else
                        begin
                            bstate <= ST_RX_ACK;
                            if (first)
                            begin
                                first <= 1'b0;
                                wr_ok <= ptr_ok(shreg);
                                o_sda_oe <= ptr_ok(shreg);
                                if (ptr_ok(shreg))
                                begin
                                    ptr <= shreg;
                                    pend_trig <= shreg <= `HTS_PTR_HUM;
                                end
                            end
                            else
                            begin
                                pend_trig <= 1'b0;
                                // result registers: a write aborts
                                abort_req <= wr_ok && ptr <= `HTS_PTR_HUM;
                                o_sda_oe <= wr_ok && ptr == `HTS_PTR_CFG;
                                if (wr_ok && ptr == `HTS_PTR_CFG)
                                begin
                                    lo_next <= !lo_next;
                                    cfg_hi <= shreg;
                                    cfg_we <= lo_next;
                                    cfg_wdata <= {cfg_hi, shreg};
                                end
                            end
                        end
                    end
                end
                ST_ADDR_ACK:
                    if (scl_fall)
                    begin
                        if (rw)
                        begin
                            tx_ptr <= ptr;
                            shreg <= ptr_word[15:8];
                            o_sda_oe <= ~ptr_word[15];
                            lo_next <= 1'b1;
                            bstate <= ST_TX;
                        end
                        else
                        begin
                            o_sda_oe <= 1'b0;
                            first <= 1'b1;
                            lo_next <= 1'b0;
                            bstate <= ST_RX;
                        end
                    end
                ST_RX_ACK:
                    if (scl_fall)
                    begin
                        o_sda_oe <= 1'b0;
                        bstate <= ST_RX;
                    end
                ST_TX:
                    if (scl_fall)
                    begin
                        if (cnt == 4'h7)
                        begin
                            cnt <= 4'h0;
                            o_sda_oe <= 1'b0;
                            bstate <= ST_TX_ACK;
                        end
                        else
                        begin
                            cnt <= cnt + 4'h1;
                            shreg <= {shreg[6:0], 1'b0};
                            o_sda_oe <= ~shreg[6];
                        end
                    end
                ST_TX_ACK:
                    if (scl_rise)
                        mack <= ~filt[1];
                    else if (scl_fall)
                    begin
                        if (mack)
                        begin
                            tx_ptr <= next_tx_ptr;
                            shreg <= next_tx_byte;
                            o_sda_oe <= ~next_tx_byte[7];
                            lo_next <= !lo_next;
                            bstate <= ST_TX;
                        end
                        else
                            bstate <= ST_IDLE;
                    end
            endcase
        end
    end

    // configuration register and supply monitor flag
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            cfg <= `HTS_CFG_RESET;
        else
        begin
            if (cfg_we)
                cfg <= (cfg & ~`HTS_CFG_WMASK) |
                       (cfg_wdata & `HTS_CFG_WMASK);
            // refreshed once at the end of start-up and per trigger;
            // the !ready term blocks it once ready is set, so this fires once
            if ((!ready && boot_cnt == 24'(P_STARTUP_CYC - 1)) || trig)
                cfg[`HTS_BIT_SUPLOW] <= filt[2];
        end
    end

    // measurement sequencing
    logic [23:0] conv_cnt;
    logic both;
    logic [23:0] conv_len;
    always_comb
    begin
        if (mstate == M_TEMP)
            conv_len = cfg[`HTS_BIT_TRES] ? 24'(P_T11_CYC) : 24'(P_T14_CYC);
        else if (cfg[`HTS_BIT_HRES1])
            conv_len = 24'(P_H8_CYC);
        else if (cfg[`HTS_BIT_HRES0])
            conv_len = 24'(P_H11_CYC);
        else
            conv_len = 24'(P_H14_CYC);
    end

    logic [15:0] t_mask;
    logic [15:0] h_mask;
    assign t_mask = cfg[`HTS_BIT_TRES] ? `HTS_MASK_11 : `HTS_MASK_14;
    assign h_mask = cfg[`HTS_BIT_HRES1] ? `HTS_MASK_8 :
                    cfg[`HTS_BIT_HRES0] ? `HTS_MASK_11 : `HTS_MASK_14;

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            mstate <= M_SLEEP;
            conv_cnt <= 24'h000000;
            both <= 1'b0;
            temp_reg <= 16'h0000;
            hum_reg <= 16'h0000;
            temp_valid <= 1'b0;
            hum_valid <= 1'b0;
        end
        else if (trig)
        begin
            conv_cnt <= 24'h000000;
            both <= ptr == `HTS_PTR_TEMP && cfg[`HTS_BIT_MODE];
            if (ptr == `HTS_PTR_TEMP)
            begin
                mstate <= M_TEMP;
                temp_valid <= 1'b0;
                if (cfg[`HTS_BIT_MODE])
                    hum_valid <= 1'b0;
            end
            else
            begin
                mstate <= M_HUM;
                hum_valid <= 1'b0;
            end
        end
        else if (abort_req)
            mstate <= M_SLEEP;
        else if (mstate != M_SLEEP)
        begin
            conv_cnt <= conv_cnt + 24'h000001;
            if (conv_cnt == conv_len - 24'h000001)
            begin
                conv_cnt <= 24'h000000;
                if (mstate == M_TEMP)
                begin
                    temp_reg <= {i_temp_result, 2'b00} & t_mask;
                    temp_valid <= 1'b1;
                    mstate <= both ? M_HUM : M_SLEEP;
                end
                else
                begin
                    hum_reg <= {i_hum_result, 2'b00} & h_mask;
                    hum_valid <= 1'b1;
                    mstate <= M_SLEEP;
                end
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            o_heater_on <= 1'b0;
        else
            o_heater_on <= cfg[`HTS_BIT_HEATER_ENABLE_BIT] && mstate != M_SLEEP;
    end

    assign o_sda_out = 1'b0;
    assign o_measuring = mstate != M_SLEEP;
    assign o_ready = ready;
    assign o_meas_state = mstate;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    a_idle_sda_free: assert property (bstate == ST_IDLE |=> !o_sda_oe ||
        $past(bus_start)) else $error("sda driven while idle");
    a_foreign_addr: assert property (bstate == ST_ADDR && scl_fall &&
        cnt == 4'h8 && !addr_match && !bus_start && !bus_stop |=>
        bstate == ST_IDLE && !o_sda_oe)
        else $error("foreign address acked");
    a_own_write_ack: assert property (bstate == ST_ADDR && scl_fall &&
        cnt == 4'h8 && addr_match && !shreg[0] && !bus_start && !bus_stop
        |=> o_sda_oe && bstate == ST_ADDR_ACK)
        else $error("own write address nacked");
    a_ptr_load: assert property (bstate == ST_RX && first && scl_fall &&
        cnt == 4'h8 && ptr_ok(shreg) && !bus_start && !bus_stop |=>
        ptr == $past(shreg) && o_sda_oe)
        else $error("pointer not loaded");
    a_bad_ptr_nack: assert property (bstate == ST_RX && first && scl_fall &&
        cnt == 4'h8 && !ptr_ok(shreg) && !bus_start && !bus_stop |=>
        !o_sda_oe ##1 !o_sda_oe)
        else $error("unknown pointer acked");
    a_ro_data_nack: assert property (bstate == ST_RX && !first &&
        scl_fall && cnt == 4'h8 && ptr >= `HTS_PTR_SER0 && !bus_start &&
        !bus_stop |=> !o_sda_oe)
        else $error("read-only data acked");
    a_msb_first: assert property (bstate == ST_TX && scl_fall &&
        cnt != 4'h7 && !bus_start && !bus_stop |=> o_sda_oe ==
        !$past(shreg[6])) else $error("bit order wrong");
    a_startup_ids: assert property (!ready && bstate == ST_TX |->
        tx_ptr >= `HTS_PTR_SER0)
        else $error("non-id read during start-up");
    a_trigger_meas: assert property (trig |=> mstate != M_SLEEP &&
        conv_cnt == 24'h000000) else $error("trigger ignored");
    a_abort_conv: assert property (abort_req && !trig |=>
        mstate == M_SLEEP) else $error("write did not abort");
    a_stale_nack: assert property (bstate == ST_ADDR && scl_fall &&
        cnt == 4'h8 && shreg[0] && ptr == `HTS_PTR_TEMP && !temp_valid
        |=> !o_sda_oe) else $error("stale result acked");
    a_heater_sleep: assert property ((mstate == M_SLEEP) [*2] |->
        !o_heater_on) else $error("heater on in sleep");

    c_trigger: cover property (trig ##1 mstate == M_TEMP);
    c_both_read: cover property (bstate == ST_TX && tx_ptr == `HTS_PTR_HUM);
    c_cfg_write: cover property (cfg_we);
    c_abort: cover property (mstate != M_SLEEP ##1 abort_req);
endmodule
`default_nettype wire

// >>> core/hts_params.svh
/*
 Constants of the humidity/temperature sensor two-wire slave: target
 address, pointer values, configuration layout, reset values and times.
 Assumes a 100 MHz core clock; times are given in ns.
*/
`ifndef HTS_PARAMS_SVH
`define HTS_PARAMS_SVH

`define HTS_CLK_PERIOD_NS 10
`define HTS_CYC(ns) ((ns) / `HTS_CLK_PERIOD_NS)

`define HTS_DEV_ADDR 7'h40

`define HTS_PTR_TEMP 8'h00
`define HTS_PTR_HUM 8'h01
`define HTS_PTR_CFG 8'h02
`define HTS_PTR_SER0 8'hFB
`define HTS_PTR_SER1 8'hFC
`define HTS_PTR_SER2 8'hFD
`define HTS_PTR_MFR 8'hFE
`define HTS_PTR_DEV 8'hFF

`define HTS_CFG_RESET 16'h1000
`define HTS_CFG_WMASK 16'h3700
`define HTS_BIT_HEATER_ENABLE_BIT 13
`define HTS_BIT_MODE 12
`define HTS_BIT_SUPLOW 11
`define HTS_BIT_TRES 10
`define HTS_BIT_HRES1 9
`define HTS_BIT_HRES0 8

`define HTS_MASK_14 16'hFFFC
`define HTS_MASK_11 16'hFFE0
`define HTS_MASK_8 16'hFF00

`define HTS_SYNC_INIT 3'h3

`define HTS_STARTUP_NS 15000000
`define HTS_T11_NS 3650000
`define HTS_T14_NS 6350000
`define HTS_H8_NS 2500000
`define HTS_H11_NS 3850000
`define HTS_H14_NS 6500000

`endif

// >>> core/hts_pkg.sv
/*
 Types of the sensor slave: bus and measurement state encodings.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hts_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_RX = 7'h08,
        ST_RX_ACK = 7'h10,
        ST_TX = 7'h20,
        ST_TX_ACK = 7'h40
    } hts_bus_state_type;

    typedef enum logic [2:0] {
        M_SLEEP = 3'h1,
        M_TEMP = 3'h2,
        M_HUM = 3'h4
    } hts_meas_state_type;
endpackage

// >>> testbench/hts_master_model.sv
/*
 Two-wire bus master model that stands opposite the sensor slave.
 Assumes an external pull-up that resolves SDA from all open-drain
 enables; SCL runs at an 80 ns period only inside transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module hts_master_model (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic start_cond();
        if (!o_scl)
        begin
            #20 o_sda_oe = 1'b0;
            #20 o_scl = 1'b1;
        end
        #20 o_sda_oe = 1'b1;
        #20 o_scl = 1'b0;
    endtask
    task automatic stop_cond();
        #20 o_sda_oe = 1'b1;
        #20 o_scl = 1'b1;
        #20 o_sda_oe = 1'b0;
        #40;
    endtask
    // the target moves SDA about 45 ns after a falling edge: a 60 ns low
    // phase keeps that move out of the high phase, where it would read
    // as a start or stop; the high phase stays at 20 ns
    task automatic bit_io(input logic b, output logic r);
        #20 o_sda_oe = !b;
        #40 o_scl = 1'b1;
        #15 r = i_sda;
        #5 o_scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] w, input logic mack,
                        output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(mack, s);
        ack = !s;
    endtask
endmodule
`default_nettype wire

// >>> testbench/hts_sensor_slave_bench.sv
/*
 Self-checking bench of the sensor slave: pointer, reads, refusals,
 measurement sequencing, heater and supply flag.
 Assumes hts_master_model drives the pins; counts are shortened.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hts_params.svh"
module hts_sensor_slave_bench;
    import hts_pkg::*;
    localparam int STARTUP = 2000;
    localparam int CONV = 300;
    // arbitrary id value, given to the design so the read is predictable
    localparam logic [15:0] DEV_ID = 16'hC3D4;
    logic clk, rst_n, scl, m_oe, s_out, s_oe, sup, heater_enable_bit, meas, ready;
    logic [13:0] t_res, h_res;
    hts_meas_state_type mst;
    wire logic sda = !m_oe && (s_oe ? s_out : 1'b1);
    int miscompares, n_checks;
    logic [2:0] a;
    logic k;
    logic [31:0] d;
    logic [15:0] cfgs [2] = '{16'h3000, 16'h1600};
    hts_master_model u_hts_master_model (.i_sda(sda), .o_scl(scl),
        .o_sda_oe(m_oe));
    hts_sensor_slave #(.P_STARTUP_CYC(STARTUP), .P_T11_CYC(CONV),
        .P_T14_CYC(CONV), .P_H8_CYC(CONV), .P_H11_CYC(CONV),
        .P_H14_CYC(CONV), .P_DEV_ID(DEV_ID)) u_hts_sensor_slave (
        .i_clock(clk),
        .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(s_out),
        .o_sda_oe(s_oe), .i_supply_low(sup), .i_temp_result(t_res),
        .i_hum_result(h_res), .o_heater_on(heater_enable_bit), .o_measuring(meas),
        .o_ready(ready), .o_meas_state(mst));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [15:0] exp_t(logic [15:0] c, logic [13:0] r);
        return {r, 2'b00} & (c[10] ? `HTS_MASK_11 : `HTS_MASK_14);
    endfunction
    function automatic logic [15:0] exp_h(logic [15:0] c, logic [13:0] r);
        return {r, 2'b00} & (c[9:8] == 2'b10 ? `HTS_MASK_8 :
            c[9:8] == 2'b01 ? `HTS_MASK_11 : `HTS_MASK_14);
    endfunction
    // pointer first in every write, data as high then low byte
    task automatic wr(logic [6:0] ad, logic [7:0] p, int nd,
                      logic [15:0] v, output logic [2:0] ak);
        logic [7:0] r;
        ak = 3'b000;
        u_hts_master_model.start_cond();
        u_hts_master_model.xfer({ad, 1'b0}, 1'b1, r, ak[2]);
        if (ak[2])
        begin
            u_hts_master_model.xfer(p, 1'b1, r, ak[1]);
            for (int i = 0; i < nd; i++)
                u_hts_master_model.xfer(i ? v[7:0] : v[15:8], 1'b1, r, ak[0]);
        end
        u_hts_master_model.stop_cond();
    endtask
    task automatic rd(int nb, output logic [31:0] v, output logic ak);
        logic [7:0] b;
        logic s;
        v = '0;
        u_hts_master_model.start_cond();
        u_hts_master_model.xfer({`HTS_DEV_ADDR, 1'b1}, 1'b1, b, ak);
        if (ak)
            for (int i = 0; i < nb; i++)
            begin
                u_hts_master_model.xfer(8'hFF, i == nb - 1, b, s);
                v = {v[23:0], b};
            end
        u_hts_master_model.stop_cond();
    endtask
    task automatic wait_for(logic want);
        for (int i = 0; i < 3000 && meas !== want; i++)
            @(negedge clk);
    endtask
    initial
    begin
        #400us;
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        rst_n = 1'b0;
        sup = 1'b0;
        t_res = '0;
        h_res = '0;
        void'($urandom(32'h9927));
        @(negedge clk);
        sup = 1'($urandom);
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        wr(`HTS_DEV_ADDR, `HTS_PTR_CFG, 0, 16'h0000, a);
        chk("early cfg ptr ack", a[1], 1'b0);
        wr(`HTS_DEV_ADDR, `HTS_PTR_DEV, 0, 16'h0000, a);
        rd(2, d, k);
        chk("early dev id", d[15:0], DEV_ID);
        wr(7'h41, `HTS_PTR_DEV, 0, 16'h0000, a);
        chk("foreign addr ack", a[2], 1'b0);
        chk("ready early", ready, 1'b0);
        for (int i = 0; i < STARTUP && ready !== 1'b1; i++)
            @(negedge clk);
        chk("ready", ready, 1'b1);
        chk("sleep at start", 16'(mst), 16'(M_SLEEP));
        wr(`HTS_DEV_ADDR, 8'h10, 0, 16'h0000, a);
        chk("unused ptr ack", a[1], 1'b0);
        wr(`HTS_DEV_ADDR, `HTS_PTR_MFR, 2, 16'h1234, a);
        chk("ro data ack", a, 3'b110);
        foreach (cfgs[j])
        begin
            wr(`HTS_DEV_ADDR, `HTS_PTR_CFG, 2, cfgs[j], a);
            chk("cfg write acks", a, 3'b111);
            @(negedge clk);
            t_res = 14'($urandom);
            h_res = 14'($urandom);
            sup = 1'($urandom);
            wr(`HTS_DEV_ADDR, `HTS_PTR_TEMP, 0, 16'h0000, a);
            chk("trigger acks", a, 3'b110);
            repeat (10) @(negedge clk);
            chk("measuring", meas, 1'b1);
            chk("heater on", heater_enable_bit, cfgs[j][13]);
            wait_for(1'b0);
            repeat (3) @(negedge clk);
            chk("heater off", heater_enable_bit, 1'b0);
            chk("back to sleep", 16'(mst), 16'(M_SLEEP));
            rd(4, d, k);
            chk("temp", d[31:16], exp_t(cfgs[j], t_res));
            chk("hum", d[15:0], exp_h(cfgs[j], h_res));
            wr(`HTS_DEV_ADDR, `HTS_PTR_CFG, 0, 16'h0000, a);
            rd(2, d, k);
            chk("cfg", d[15:0], cfgs[j] | (16'(sup) << 11));
        end
        wr(`HTS_DEV_ADDR, `HTS_PTR_TEMP, 0, 16'h0000, a);
        rd(2, d, k);
        chk("stale read ack", k, 1'b0);
        chk("read keeps conv", meas, 1'b1);
        wr(`HTS_DEV_ADDR, `HTS_PTR_TEMP, 2, 16'h0000, a);
        repeat (10) @(negedge clk);
        chk("aborted", meas, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
